// [src/eep_spi_ctrl.sv]
// Serial EEPROM command, protection and page-write controller
// What this block does
// - Sample input bits on rising serial clock
// - Change output bit on falling serial clock
// - Select high: output released, standby
// - First eight bits form op-code; others ignored
// - Six op-codes decoded to fixed values
// - Status bit layout: enable, zeros, protect, latch, busy
// - Busy set during write cycle, read-only
// - Set/clear latch commands drive the latch
// - Block-protect bits loaded only by status write
// - Protect code selects protected address range
// - Latch and pin gate writes
// - Latch cleared at power-up
// - Latch set only on select rise after eight bits
// - Sixteen address clocks, low thirteen bits used
// - Programming starts on select rise
// - While busy only status read accepted
// - Up to 64 bytes, wrap inside page
// - Write cycle end clears the latch
// - Pin affects status writes only when enabled
// - Status write changes bits 7, 3, 2 only
// - Hold releases output, ignores input
// - Memory read streams with address wrap
`timescale 1ns/1ps
module eep_spi_ctrl
  import eep_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins from the host
  input wire eep_pins_s pins,
  // Serial data output pin
  output logic soOut,
  output logic soOe
);

  eep_state_s state_reg;
  eep_state_s state_next;
  eep_pins_s p;
  logic sckRise;
  logic sckFall;
  logic csRise;
  logic csFall;
  logic linkLive;
  logic [7:0] statusByte;
  logic arrWe;
  logic [ADDR_W-1:0] arrAddr;
  logic [DATA_W-1:0] arrWdata;
  logic [DATA_W-1:0] arrRdata;
  logic bufWe;
  logic [COL_W-1:0] bufAddr;
  logic [DATA_W-1:0] bufWdata;
  logic [DATA_W-1:0] bufRdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Array and page buffer
  eep_mem #(.AW(ADDR_W), .DW(DATA_W)) arrayMem (
    .clk(clk),
    .we(arrWe),
    .addr(arrAddr),
    .wdata(arrWdata),
    .rdata(arrRdata)
  );

  eep_mem #(.AW(COL_W), .DW(DATA_W)) pageBuf (
    .clk(clk),
    .we(bufWe),
    .addr(bufAddr),
    .wdata(bufWdata),
    .rdata(bufRdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Block protection lookup
  function automatic logic isProtected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b1;
    case (bp)
      BP_NONE: hit = 1'b0;
      BP_QUARTER: hit = (a >= QUARTER_BASE);
      BP_HALF: hit = (a >= HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : isProtected

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins
  assign p = state_reg.sync2;
  assign sckRise = p.sck & ~state_reg.sckPrev;
  assign sckFall = ~p.sck & state_reg.sckPrev;
  assign csRise = p.csN & ~state_reg.csPrev;
  assign csFall = ~p.csN & state_reg.csPrev;
  assign linkLive = ~p.csN & p.holdN;

  // Live status byte
  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_PIN_PROTECT_EN] = state_reg.pinProtectEnable;
    statusByte[ST_BLOCK_PROTECT_HIGH] = state_reg.blockProtect[1];
    statusByte[ST_BLOCK_PROTECT_LOW] = state_reg.blockProtect[0];
    statusByte[ST_WRITE_LATCH] = state_reg.writeEnableLatch;
    statusByte[ST_BUSY] = state_reg.busy;
  end

  // Output pin released outside select, during hold and outside read phases
  assign soOut = state_reg.soOut;
  assign soOe = state_reg.outActive & linkLive;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [7:0] sh;
    logic [15:0] ash;
    sh = {state_reg.shiftIn[6:0], p.si};
    ash = {state_reg.addrShift[14:0], p.si};
    state_next = state_reg;
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.sckPrev = p.sck;
    state_next.csPrev = p.csN;
    state_next.rdPend = 1'b0;
    arrWe = 1'b0;
    arrAddr = state_reg.addr;
    arrWdata = bufRdata;
    bufWe = 1'b0;
    bufAddr = state_reg.col;
    bufWdata = sh;

    // Prefetched array byte arrives one cycle after its request
    if (state_reg.rdPend) begin
      state_next.nextByte = arrRdata;
    end

    // Internal write cycle: walk the page buffer, then wait out the cycle time
    if (state_reg.busy) begin
      state_next.timer = state_reg.timer + 1'b1;
      state_next.walkValid = 1'b0;
      if (state_reg.prog && !state_reg.walkIdx[COL_W]) begin
        bufAddr = state_reg.walkIdx[COL_W-1:0];
        state_next.walkIdx = state_reg.walkIdx + 1'b1;
        state_next.walkValid = 1'b1;
        state_next.walkCol = state_reg.walkIdx[COL_W-1:0];
      end
      if (state_reg.walkValid && state_reg.mask[state_reg.walkCol]) begin
        arrWe = 1'b1;
        arrAddr = {state_reg.addr[ADDR_W-1:COL_W], state_reg.walkCol};
      end
      if (state_reg.timer == TIMER_W'(WRITE_CYCLES - 1)) begin
        state_next.busy = 1'b0;
        state_next.prog = 1'b0;
        state_next.writeEnableLatch = 1'b0;
      end
    end

    if (csFall) begin
      // New transaction, any clock idle level accepted
      state_next.phase = PH_CMD;
      state_next.bitCnt = 3'h0;
      state_next.extra = 1'b0;
      state_next.gotByte = 1'b0;
      state_next.outActive = 1'b0;
      state_next.outBit = 3'h0;
    end else if (csRise) begin
      // Select rise ends the transaction and commits what it carried
      state_next.phase = PH_IDLE;
      state_next.outActive = 1'b0;
      case (state_reg.phase)
        PH_DONE: begin
          if (!state_reg.extra && state_reg.cmd == OP_SET_LATCH) begin
            state_next.writeEnableLatch = 1'b1;
          end
          if (!state_reg.extra && state_reg.cmd == OP_CLEAR_LATCH) begin
            state_next.writeEnableLatch = 1'b0;
          end
        end
        PH_WDATA: begin
          if (state_reg.gotByte && state_reg.bitCnt == 3'h0 && state_reg.writeEnableLatch
              && !isProtected(state_reg.blockProtect, state_reg.addr)) begin
            state_next.busy = 1'b1;
            state_next.prog = 1'b1;
            state_next.timer = '0;
            state_next.walkIdx = '0;
            state_next.walkValid = 1'b0;
          end
        end
        PH_SRWRITE: begin
          if (state_reg.gotByte && state_reg.bitCnt == 3'h0 && state_reg.writeEnableLatch
              && !(state_reg.pinProtectEnable && !p.wpN)) begin
            state_next.busy = 1'b1;
            state_next.prog = 1'b0;
            state_next.timer = '0;
            state_next.pinProtectEnable = state_reg.statusNew[ST_PIN_PROTECT_EN];
            state_next.blockProtect = {state_reg.statusNew[ST_BLOCK_PROTECT_HIGH],
                                       state_reg.statusNew[ST_BLOCK_PROTECT_LOW]};
          end
        end
        default: begin
        end
      endcase
    end else if (linkLive && sckRise) begin
      // Input bit capture
      state_next.shiftIn = sh;
      state_next.bitCnt = state_reg.bitCnt + 1'b1;
      case (state_reg.phase)
        PH_CMD: begin
          if (state_reg.bitCnt == BYTE_LAST_BIT) begin
            state_next.cmd = sh;
            state_next.phase = PH_IDLE;
            if (!state_reg.busy || sh == OP_READ_STATUS) begin
              case (sh)
                OP_SET_LATCH, OP_CLEAR_LATCH: state_next.phase = PH_DONE;
                OP_READ_STATUS: begin
                  state_next.phase = PH_SRREAD;
                  state_next.nextByte = statusByte;
                end
                OP_WRITE_STATUS: state_next.phase = PH_SRWRITE;
                OP_READ_MEM, OP_WRITE_MEM: begin
                  state_next.phase = PH_ADDR;
                  state_next.addrBits = 5'h00;
                end
                default: state_next.phase = PH_IDLE;
              endcase
            end
          end
        end
        PH_ADDR: begin
          state_next.addrShift = ash;
          state_next.addrBits = state_reg.addrBits + 1'b1;
          if (state_reg.addrBits == ADDR_LAST_BIT) begin
            state_next.addr = ash[ADDR_W-1:0];
            if (state_reg.cmd == OP_READ_MEM) begin
              state_next.phase = PH_RDATA;
              arrAddr = ash[ADDR_W-1:0];
              state_next.rdPend = 1'b1;
            end else begin
              state_next.phase = PH_WDATA;
              state_next.col = ash[COL_W-1:0];
              state_next.mask = '0;
            end
          end
        end
        PH_WDATA: begin
          if (state_reg.bitCnt == BYTE_LAST_BIT) begin
            bufWe = 1'b1;
            state_next.mask[state_reg.col] = 1'b1;
            state_next.col = state_reg.col + 1'b1;
            state_next.gotByte = 1'b1;
          end
        end
        PH_SRWRITE: begin
          if (state_reg.bitCnt == BYTE_LAST_BIT) begin
            state_next.statusNew = sh;
            state_next.gotByte = 1'b1;
          end
        end
        PH_DONE: state_next.extra = 1'b1;
        default: begin
        end
      endcase
    end else if (linkLive && sckFall
                 && (state_reg.phase == PH_RDATA || state_reg.phase == PH_SRREAD)) begin
      // Output bit shift on the falling edge
      state_next.outActive = 1'b1;
      state_next.outBit = state_reg.outBit + 1'b1;
      if (state_reg.outBit == 3'h0) begin
        state_next.soOut = state_reg.nextByte[7];
        state_next.outShift = {state_reg.nextByte[6:0], 1'b0};
        if (state_reg.phase == PH_RDATA) begin
          state_next.addr = state_reg.addr + 1'b1;
          arrAddr = state_reg.addr + 1'b1;
          state_next.rdPend = 1'b1;
        end else begin
          state_next.nextByte = statusByte;
        end
      end else begin
        state_next.soOut = state_reg.outShift[7];
        state_next.outShift = {state_reg.outShift[6:0], 1'b0};
      end
    end

    // Power-on state: latch cleared, select seen high, protection at factory value
    if (!reset_n) begin
      state_next = '0;
      state_next.sync1.csN = 1'b1;
      state_next.sync2.csN = 1'b1;
      state_next.csPrev = 1'b1;
      state_next.blockProtect = BP_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

endmodule : eep_spi_ctrl

// [src/eep_pkg.sv]
// Shared constants, pin bundle and controller state for the serial EEPROM core
package eep_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int COL_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ROW_W = ADDR_W - COL_W;
  localparam int ADDR_CLOCKS = 16;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h0F;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Op-codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_MEM = 8'h03;
  localparam logic [7:0] OP_WRITE_MEM = 8'h02;

  ////////////////////////////////////////////////////////////////////////////////
  // Status register layout and block boundaries
  localparam int ST_PIN_PROTECT_EN = 7;
  localparam int ST_BLOCK_PROTECT_HIGH = 3;
  localparam int ST_BLOCK_PROTECT_LOW = 2;
  localparam int ST_WRITE_LATCH = 1;
  localparam int ST_BUSY = 0;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [12:0] QUARTER_BASE = 13'h1800;
  localparam logic [12:0] HALF_BASE = 13'h1000;
  localparam logic [1:0] BP_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_NS = 5000000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic csN;
    logic sck;
    logic si;
    logic holdN;
    logic wpN;
  } eep_pins_s;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_SRREAD,
    PH_SRWRITE,
    PH_DONE
  } eep_phase_e;

  typedef struct packed {
    eep_pins_s sync1;
    eep_pins_s sync2;
    logic sckPrev;
    logic csPrev;
    eep_phase_e phase;
    logic ignoring;
    logic [7:0] cmd;
    logic [7:0] shiftIn;
    logic [2:0] bitCnt;
    logic [4:0] addrBits;
    logic [15:0] addrShift;
    logic [ADDR_W-1:0] addr;
    logic [COL_W-1:0] col;
    logic gotByte;
    logic extra;
    logic [PAGE_BYTES-1:0] mask;
    logic [7:0] statusNew;
    logic pinProtectEnable;
    logic [1:0] blockProtect;
    logic writeEnableLatch;
    logic busy;
    logic prog;
    logic [TIMER_W-1:0] timer;
    logic [COL_W:0] walkIdx;
    logic walkValid;
    logic [COL_W-1:0] walkCol;
    logic [7:0] outShift;
    logic [7:0] nextByte;
    logic [2:0] outBit;
    logic outActive;
    logic soOut;
    logic rdPend;
  } eep_state_s;

endpackage : eep_pkg

// [src/eep_mem.sv]
// Single-port byte memory with registered read data
`timescale 1ns/1ps
module eep_mem
  import eep_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Write when enabled; read the old cell into the output register every cycle
  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end

endmodule : eep_mem

// [test/eep_spi_ctrl_properties.sv]
// Pin-level timing checks for the serial EEPROM controller
`timescale 1ns/1ps
module eep_spi_ctrl_properties
  import eep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire eep_pins_s pins,
  input wire logic soOut,
  input wire logic soOe
);
  logic sckPrev;
  logic [7:0] riseCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Counts serial clock rises in the current frame, outside pauses
  always_ff @(posedge clk) begin
    sckPrev <= pins.sck;
    if (pins.csN) begin
      riseCnt <= 8'h00;
    end else if (pins.sck && !sckPrev && pins.holdN && riseCnt != 8'hFF) begin
      riseCnt <= riseCnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Output pin behaviour
  a_idle_released: assert property (pins.csN [*4] |-> !soOe)
    else $error("output driven while deselected");
  a_out_in_frame: assert property (soOe |-> !$past(pins.csN, 5))
    else $error("output still driven after select rose");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !soOe && !soOut)
    else $error("output active in reset");
  a_hold_released: assert property ((!pins.holdN) [*4] |-> !soOe)
    else $error("output driven during pause");
  a_fall_change: assert property (
    soOe && $past(soOe) && $changed(soOut) |-> !$past(pins.sck, 2))
    else $error("output bit changed away from a falling clock");
  a_high_steady: assert property (
    soOe && $past(soOe) && pins.sck && $past(pins.sck, 3) |-> $stable(soOut))
    else $error("output bit moved while clock high");
  a_first_fall: assert property ($rose(soOe) |-> !$past(pins.sck, 2))
    else $error("output enabled away from a falling clock");
  a_opcode_first: assert property ($rose(soOe) |-> riseCnt >= 8'h08)
    else $error("output enabled before eight op-code bits");
  // Main scenarios
  c_out: cover property ($rose(soOe));
  c_mode3: cover property ($fell(pins.csN) && pins.sck);
  c_pause: cover property ($fell(pins.holdN) && !pins.csN);
endmodule : eep_spi_ctrl_properties

bind eep_spi_ctrl eep_spi_ctrl_properties eep_spi_ctrl_properties_inst (
  .clk(clk), .reset_n(reset_n), .pins(pins), .soOut(soOut), .soOe(soOe));

// [test/eep_host.sv]
// Behavioural host SPI master for the serial EEPROM controller
`timescale 1ns/1ps
module eep_host
  import eep_pkg::*;
(
  // Clock
  input wire logic clk,
  // Serial pins
  output eep_pins_s pins,
  input wire logic soOut,
  input wire logic soOe
);
  logic mode3;
  wire logic so = soOe ? soOut : 1'bz;
  ////////////////////////////////////////////////////////////////////////////////
  // Deselected, pause unused, protect pin high
  initial begin
    pins = '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1, wpN: 1'b1};
    mode3 = 1'b0;
  end
  // Waits n cycles, then steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic set_wp(input logic v);
    pins.wpN = v;
  endtask : set_wp
  // Selects with the clock at the mode's idle level
  task automatic begin_frame(input logic m3);
    mode3 = m3;
    pins.sck = m3;
    tick(4);
    pins.csN = 1'b0;
    tick(4);
  endtask : begin_frame
  // One byte each way, MSB first; data moves only with clock low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.sck = 1'b0;
      pins.si = tx[i];
      tick(4);
      rx[i] = so;
      pins.sck = 1'b1;
      tick(4);
    end
  endtask : xfer
  // Returns clock to idle, deselects four cycles later; input data line then toggles while deselected
  task automatic end_frame();
    pins.sck = mode3;
    tick(4);
    pins.csN = 1'b1;
    pins.si = ~pins.si;
    tick(8);
  endtask : end_frame
  // Pauses with clock low, wiggles clock and data, resumes
  task automatic hold_pause(output logic [7:0] seen);
    pins.sck = 1'b0;
    tick(4);
    pins.holdN = 1'b0;
    tick(4);
    repeat (2) begin
      pins.sck = 1'b1;
      pins.si = ~pins.si;
      tick(4);
      pins.sck = 1'b0;
      tick(4);
    end
    seen = {8{so}};
    pins.holdN = 1'b1;
    tick(4);
  endtask : hold_pause
endmodule : eep_host

// [test/eep_spi_ctrl_tb.sv]
// Self-checking bench for the serial EEPROM controller
`timescale 1ns/1ps
module eep_spi_ctrl_tb
  import eep_pkg::*;
;
  localparam int WCYC = 400;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  eep_pins_s pins;
  logic soOut;
  logic soOe;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] rx;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and host
  eep_spi_ctrl #(.WRITE_CYCLES(WCYC)) eep_spi_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .pins(pins), .soOut(soOut), .soOe(soOe));
  eep_host eep_host_inst (.clk(clk), .pins(pins), .soOut(soOut), .soOe(soOe));
  // Clock and hang ceiling
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  // Frame helpers
  task automatic cmd(input logic [7:0] op, input logic m3);
    eep_host_inst.begin_frame(m3);
    eep_host_inst.xfer(op, rx);
    eep_host_inst.end_frame();
  endtask : cmd
  task automatic st_is(input logic [7:0] exp, input logic m3);
    eep_host_inst.begin_frame(m3);
    eep_host_inst.xfer(OP_READ_STATUS, rx);
    eep_host_inst.xfer(8'h00, rx);
    eep_host_inst.end_frame();
    check8("status", exp, rx);
  endtask : st_is
  task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d, input int n);
    eep_host_inst.begin_frame(1'b0);
    eep_host_inst.xfer(op, rx);
    if (op == OP_WRITE_MEM) begin
      eep_host_inst.xfer(a[15:8], rx);
      eep_host_inst.xfer(a[7:0], rx);
    end
    for (int i = 0; i < n; i++) eep_host_inst.xfer(8'(d + i), rx);
    eep_host_inst.end_frame();
  endtask : wr
  // Memory read of two bytes in the given mode; the second byte shows the increment
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1,
                     input logic m3);
    eep_host_inst.begin_frame(m3);
    eep_host_inst.xfer(OP_READ_MEM, rx);
    eep_host_inst.xfer(a[15:8], rx);
    eep_host_inst.xfer(a[7:0], rx);
    eep_host_inst.xfer(8'h00, rx);
    check8("read first", e0, rx);
    eep_host_inst.xfer(8'h00, rx);
    check8("read next", e1, rx);
    eep_host_inst.end_frame();
  endtask : rd2
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_opcodes();
    st_is(8'h00, 1'b0);
    cmd(OP_SET_LATCH, 1'b0);
    st_is(8'h02, 1'b1);
    cmd(OP_CLEAR_LATCH, 1'b1);
    st_is(8'h00, 1'b0);
    eep_host_inst.begin_frame(1'b0);
    eep_host_inst.xfer(OP_SET_LATCH, rx);
    eep_host_inst.xfer(8'h00, rx);
    eep_host_inst.end_frame();
    st_is(8'h00, 1'b0);
    eep_host_inst.begin_frame(1'b0);
    eep_host_inst.xfer(8'h85, rx);
    eep_host_inst.xfer(8'h00, rx);
    eep_host_inst.end_frame();
    check8("unknown op", 8'hzz, rx);
    wr(OP_WRITE_MEM, 16'h0100, 8'h55, 1);
    st_is(8'h00, 1'b0);
  endtask : t_opcodes
  task automatic t_protect();
    logic [12:0] base;
    logic acc;
    for (int c = 0; c < 4; c++) begin
      cmd(OP_SET_LATCH, 1'b0);
      wr(OP_WRITE_STATUS, 16'h0000, {4'h7, 2'(c), 2'h3}, 1);
      eep_host_inst.tick(WCYC + 30);
      st_is({4'h0, 2'(c), 2'h0}, 1'b0);
      base = (c == 1) ? 13'h1800 : (c == 2) ? 13'h1000 : 13'h0000;
      for (int k = 0; k < 2; k++) begin
        acc = (c == 0) || (c != 3 && k == 0);
        cmd(OP_SET_LATCH, 1'b0);
        wr(OP_WRITE_MEM, {3'h0, 13'(base - 13'h0001 + k)}, 8'(8'hC0 + 2 * c + k), 1);
        st_is({4'h0, 2'(c), 1'b1, acc}, 1'b0);
        eep_host_inst.tick(WCYC + 30);
      end
    end
  endtask : t_protect
  task automatic t_pin();
    cmd(OP_SET_LATCH, 1'b0);
    wr(OP_WRITE_STATUS, 16'h0000, 8'h80, 1);
    eep_host_inst.tick(WCYC + 30);
    st_is(8'h80, 1'b0);
    eep_host_inst.set_wp(1'b0);
    cmd(OP_SET_LATCH, 1'b0);
    wr(OP_WRITE_STATUS, 16'h0000, 8'h00, 1);
    st_is(8'h82, 1'b0);
    eep_host_inst.set_wp(1'b1);
    wr(OP_WRITE_STATUS, 16'h0000, 8'h00, 1);
    // New protection bits apply at the select rise that starts the cycle
    st_is(8'h03, 1'b0);
    eep_host_inst.tick(WCYC + 30);
    st_is(8'h00, 1'b0);
  endtask : t_pin
  task automatic t_page();
    cmd(OP_SET_LATCH, 1'b0);
    wr(OP_WRITE_MEM, 16'hE03E, 8'hA0, 4);
    st_is(8'h03, 1'b0);
    rd2(16'h0000, 8'hzz, 8'hzz, 1'b0);
    eep_host_inst.tick(WCYC + 30);
    st_is(8'h00, 1'b0);
    rd2(16'hE03E, 8'hA0, 8'hA1, 1'b1);
    rd2(16'h0000, 8'hA2, 8'hA3, 1'b0);
    rd2(16'h1FFF, 8'hC0, 8'hA2, 1'b1);
  endtask : t_page
  task automatic t_hold();
    cmd(OP_SET_LATCH, 1'b0);
    eep_host_inst.begin_frame(1'b0);
    eep_host_inst.xfer(OP_READ_STATUS, rx);
    eep_host_inst.hold_pause(rx);
    check8("paused output", 8'hzz, rx);
    eep_host_inst.xfer(8'h00, rx);
    eep_host_inst.end_frame();
    check8("status after pause", 8'h02, rx);
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    eep_host_inst.tick(4);
    t_opcodes();
    t_protect();
    t_pin();
    t_page();
    t_hold();
    give_verdict();
  end
endmodule : eep_spi_ctrl_tb
